// File: include/acc_pkg.sv
// Purpose: shared constants for the channel configuration command port
// Assumes: eight half-duplex channels, seven-byte setup records
// Notes:   register offsets are byte addresses on classic wishbone

package acc_pkg;

	// ------------------------------------------------------------
	// channel layout
	// ------------------------------------------------------------
	localparam int CH_NUM    = 8;
	localparam int REC_LEN   = 7;
	localparam int DEC_CH    = 4;
	localparam int SLOT_SPACE   = 16;
	localparam int ADPCM_BITS   = 4;
	localparam int PCM_BITS     = 8;

	// ------------------------------------------------------------
	// command bytes
	// ------------------------------------------------------------
	localparam logic [5:0] PCC_HDR_PAT = 6'h0c;
	localparam logic [7:0] REC_HDR     = 8'h00;
	localparam logic [7:0] REC_END     = 8'hff;

	// record byte positions
	localparam int RB_ROUTE  = 0;
	localparam int RB_ALG    = 1;
	localparam int RB_RSV    = 2;
	localparam int RB_IN_B   = 3;
	localparam int RB_IN_E   = 4;
	localparam int RB_OUT_B  = 5;
	localparam int RB_OUT_E  = 6;
	localparam int RT_IN_BIT  = 7;
	localparam int RT_OUT_BIT = 6;
	localparam int ALG_DEC_BIT = 6;

	// per-channel low byte flags
	localparam int LO_RESET  = 4;
	localparam int LO_BYPASS = 3;
	localparam int LO_ALAW   = 2;
	localparam int LO_IDLE   = 0;

	// ------------------------------------------------------------
	// defaults and output codes
	// ------------------------------------------------------------
	localparam logic [7:0] ROUTE_DEC = 8'hd0;
	localparam logic [7:0] ROUTE_ENC = 8'h10;
	localparam logic [7:0] ALG_DEC   = 8'h5e;
	localparam logic [7:0] ALG_ENC   = 8'h1e;
	localparam logic [7:0] LO_RST_VAL = 8'h10;
	localparam logic [7:0] HI_RST_VAL = 8'h00;
	localparam logic [7:0] CODE_FF   = 8'hff;
	localparam logic [7:0] CODE_ALAW = 8'hd5;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam logic [ADR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADR_W-1:0] REG_SEL    = 8'h08;
	localparam logic [ADR_W-1:0] REG_CTL    = 8'h0c;
	localparam logic [ADR_W-1:0] REG_REC0   = 8'h10;
	localparam logic [ADR_W-1:0] REG_REC1   = 8'h14;
	localparam logic [1:0] CTRL_RST_VAL = 2'h1;

	typedef enum logic [2:0] {
		ACC_IDLE, ACC_PCC_START, ACC_PCC_HI, ACC_PCC_LO,
		ACC_REC, ACC_SKIP
	} acc_state_t;

	// default setup record byte for a channel
	function automatic logic [7:0] def_rec(input int ch, input int idx);
		logic [7:0] base;
		logic       dec;
		dec  = (ch < DEC_CH);
		base = 8'((ch % DEC_CH) * SLOT_SPACE);
		case (idx)
			RB_ROUTE: def_rec = dec ? ROUTE_DEC : ROUTE_ENC;
			RB_ALG:   def_rec = dec ? ALG_DEC : ALG_ENC;
			RB_IN_B,
			RB_OUT_B: def_rec = base;
			RB_IN_E:  def_rec = base + 8'(dec ? ADPCM_BITS-1 : PCM_BITS-1);
			RB_OUT_E: def_rec = base + 8'(dec ? PCM_BITS-1 : ADPCM_BITS-1);
			default:  def_rec = 8'h00;
		endcase
	endfunction

endpackage

// File: core/acc_sync_edge.sv
// Purpose: two-stage synchroniser with edge detect
// Assumes: input asynchronous to clk_i
// Notes:   edges come from the second and third stages only

`timescale 1ns/1ns
`default_nettype none

module acc_sync_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] level_o,
	output logic      [WIDTH-1:0] rise_o,
	output logic      [WIDTH-1:0] fall_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] dly_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
			dly_q  <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
			dly_q  <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~dly_q;
	assign fall_o  = ~sync_q & dly_q;

endmodule // acc_sync_edge

`default_nettype wire

// File: core/acc_byte_rx.sv
// Purpose: assembles command bytes, msb first, on command clock rises
// Assumes: inputs already synchronised to clk_i
// Notes:   a partial byte is dropped when select goes inactive

`timescale 1ns/1ns
`default_nettype none

module acc_byte_rx (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sclk_rise_i,
	input  wire logic       sdata_i,
	input  wire logic       select_n_i,
	output logic            byte_valid_o,
	output logic      [7:0] byte_o
);

	logic [7:0] shift_q;
	logic [2:0] cnt_q;
	logic       take;

	assign take = sclk_rise_i & ~select_n_i;

	always_ff @(posedge clk_i) begin
		if (rst_i || select_n_i) begin
			cnt_q   <= '0;
			shift_q <= '0;
		end else if (take) begin
			cnt_q   <= cnt_q + 3'h1;
			shift_q <= {shift_q[6:0], sdata_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byte_valid_o <= 1'b0;
			byte_o       <= '0;
		end else begin
			byte_valid_o <= take && (cnt_q == 3'h7);
			if (take && (cnt_q == 3'h7))
				byte_o <= {shift_q[6:0], sdata_i};
		end
	end

endmodule // acc_byte_rx

`default_nettype wire

// File: core/acc_cmd_port.sv
// Purpose: serial command interpreter holding eight channel setups
// Assumes: command pins and frame sync are asynchronous to clk_i
// Notes:   new settings go live on the next frame sync rise
//
// What this block does
// - per-channel control needs its two-bit chip id to match the id pins; 0x00 setup records are taken with no id check
// - channels numbered in processing order; 0-3 decode, 4-7 encode
// - decode channel takes adpcm codewords in, gives pcm samples out
// - encode channel takes pcm samples in, gives adpcm codewords out
// - header 0x30 (id zero) opens per-channel control
// - next byte names the first channel configured
// - then high and low byte per channel, ascending; zeros mean normal
// - 0x00 opens seven-byte setup records from channel zero upward
// - record byte 1: bit7 input port, bit6 output port, one means y
// - record byte 2 is algorithm code; decode default 0x5e
// - encode channel algorithm code defaults to 0x1e
// - bytes 4-7: inclusive input and output slot begin/end bits
// - adpcm slot four bits, pcm eight, channels spaced by sixteen
// - 0xff ends the setup record sequence
// - header bits 7:2 are 001100, bits 1:0 chip id; length 2+2n
// - low byte flags: reset, bypass, a-law, idle tristate
// - under reset flag: encoder 0xff, decoder 0xff mu-law, 0xd5 a-law

`timescale 1ns/1ns
`default_nettype none

module acc_cmd_port
	import acc_pkg::*;
#(
	parameter int CH = acc_pkg::CH_NUM
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [acc_pkg::ADR_W-1:0] wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic                  wb_we_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic                  command_clock_i,
	input  wire logic                  command_serial_in_i,
	input  wire logic                  command_select_n_i,
	input  wire logic                  chip_id_high_i,
	input  wire logic                  chip_id_low_i,
	input  wire logic                  frame_sync_i,
	output logic      [CH-1:0]         chan_decode_o,
	output logic      [CH-1:0]         route_in_y_o,
	output logic      [CH-1:0]         route_out_y_o,
	output logic      [CH*8-1:0]       alg_code_o,
	output logic      [CH*8-1:0]       in_slot_begin_o,
	output logic      [CH*8-1:0]       in_slot_end_o,
	output logic      [CH*8-1:0]       out_slot_begin_o,
	output logic      [CH*8-1:0]       out_slot_end_o,
	output logic      [CH-1:0]         algo_reset_o,
	output logic      [CH-1:0]         bypass_o,
	output logic      [CH-1:0]         alaw_select_o,
	output logic      [CH-1:0]         idle_tristate_o,
	output logic      [CH*8-1:0]       reset_code_o,
	output logic                       config_pending_o
);
	import acc_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers and byte assembly
	// ------------------------------------------------------------
	logic       sclk_rise;
	logic       sdata;
	logic       sel_n;
	logic       sel_rise;
	logic [1:0] chip_id;
	logic       fs_rise;
	logic       byte_valid;
	logic [7:0] rx_byte;

	acc_sync_edge #(.WIDTH(1)) u_sclk (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (command_clock_i),
		.level_o (),
		.rise_o  (sclk_rise),
		.fall_o  ()
	);

	acc_sync_edge #(.WIDTH(1)) u_sdata (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (command_serial_in_i),
		.level_o (sdata),
		.rise_o  (),
		.fall_o  ()
	);

	// select resets high so an idle port stays deselected
	acc_sync_edge #(.WIDTH(1)) u_sel (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (~command_select_n_i),
		.level_o (),
		.rise_o  (),
		.fall_o  (sel_rise)
	);

	logic sel_act;
	acc_sync_edge #(.WIDTH(1)) u_sel_lvl (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (~command_select_n_i),
		.level_o (sel_act),
		.rise_o  (),
		.fall_o  ()
	);
	assign sel_n = ~sel_act;

	acc_sync_edge #(.WIDTH(2)) u_id (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({chip_id_high_i, chip_id_low_i}),
		.level_o (chip_id),
		.rise_o  (),
		.fall_o  ()
	);

	acc_sync_edge #(.WIDTH(1)) u_fs (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (frame_sync_i),
		.level_o (),
		.rise_o  (fs_rise),
		.fall_o  ()
	);

	acc_byte_rx u_rx (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.sclk_rise_i  (sclk_rise),
		.sdata_i      (sdata),
		.select_n_i   (sel_n),
		.byte_valid_o (byte_valid),
		.byte_o       (rx_byte)
	);

	// ------------------------------------------------------------
	// command interpreter
	// ------------------------------------------------------------
	acc_state_t state_q;
	logic [7:0] chan_q;
	logic [2:0] ridx_q;
	logic [7:0] sh_rec_q [CH][REC_LEN];
	logic [7:0] sh_hi_q  [CH];
	logic [7:0] sh_lo_q  [CH];
	logic       enable_q;
	logic       wr_shadow;
	logic [7:0] cmd_cnt_q;
	logic [7:0] ign_cnt_q;
	logic       hdr_pcc;

	// header match needs both pattern and own id
	assign hdr_pcc = (rx_byte[7:2] == PCC_HDR_PAT) &&
		(rx_byte[1:0] == chip_id);

	always_ff @(posedge clk_i) begin
		if (rst_i || sel_rise) begin
			state_q <= ACC_IDLE;
		end else if (byte_valid) begin
			unique case (state_q)
				ACC_IDLE: begin
					if (!enable_q)
						state_q <= ACC_SKIP;
					else if (hdr_pcc)
						state_q <= ACC_PCC_START;
					else if (rx_byte == REC_HDR)
						state_q <= ACC_REC;
					else
						state_q <= ACC_SKIP;
				end
				ACC_PCC_START: state_q <= ACC_PCC_HI;
				ACC_PCC_HI:    state_q <= ACC_PCC_LO;
				ACC_PCC_LO:    state_q <= ACC_PCC_HI;
				ACC_REC: begin
					if (ridx_q == 3'h0 && rx_byte == REC_END)
						state_q <= ACC_SKIP;
				end
				ACC_SKIP:      state_q <= ACC_SKIP;
			endcase
		end
	end

	// channel pointer and record byte index
	always_ff @(posedge clk_i) begin
		if (rst_i || sel_rise) begin
			chan_q <= '0;
			ridx_q <= '0;
		end else if (byte_valid) begin
			if (state_q == ACC_IDLE) begin
				chan_q <= '0;
				ridx_q <= '0;
			end else if (state_q == ACC_PCC_START) begin
				chan_q <= rx_byte;
			end else if (state_q == ACC_PCC_LO) begin
				chan_q <= chan_q + 8'h1;
			end else if (state_q == ACC_REC) begin
				if (ridx_q == 3'(REC_LEN-1)) begin
					ridx_q <= '0;
					chan_q <= chan_q + 8'h1;
				end else begin
					ridx_q <= ridx_q + 3'h1;
				end
			end
		end
	end

	// bytes aimed past the last channel are dropped
	assign wr_shadow = byte_valid && (chan_q < 8'(CH)) &&
		(state_q == ACC_PCC_HI || state_q == ACC_PCC_LO ||
		(state_q == ACC_REC && !(ridx_q == 3'h0 && rx_byte == REC_END)));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < CH; c++) begin
				sh_hi_q[c] <= HI_RST_VAL;
				sh_lo_q[c] <= LO_RST_VAL;
				for (int b = 0; b < REC_LEN; b++)
					sh_rec_q[c][b] <= def_rec(c, b);
			end
		end else if (wr_shadow) begin
			unique case (state_q)
				ACC_PCC_HI: sh_hi_q[chan_q[2:0]] <= rx_byte;
				ACC_PCC_LO: sh_lo_q[chan_q[2:0]] <= rx_byte;
				default:    sh_rec_q[chan_q[2:0]][ridx_q] <= rx_byte;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_cnt_q <= '0;
			ign_cnt_q <= '0;
		end else if (byte_valid && state_q == ACC_IDLE) begin
			if (enable_q && (hdr_pcc || rx_byte == REC_HDR))
				cmd_cnt_q <= cmd_cnt_q + 8'h1;
			else
				ign_cnt_q <= ign_cnt_q + 8'h1;
		end
	end

	// ------------------------------------------------------------
	// frame-aligned apply
	// ------------------------------------------------------------
	logic [7:0] act_rec_q [CH][REC_LEN];
	logic [7:0] act_hi_q  [CH];
	logic [7:0] act_lo_q  [CH];

	// a write in the apply cycle keeps pending set
	always_ff @(posedge clk_i) begin
		if (rst_i)
			config_pending_o <= 1'b0;
		else
			config_pending_o <= (config_pending_o & ~fs_rise) | wr_shadow;
	end

	// shadow is copied whole, never mixed mid-frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < CH; c++) begin
				act_hi_q[c] <= HI_RST_VAL;
				act_lo_q[c] <= LO_RST_VAL;
				for (int b = 0; b < REC_LEN; b++)
					act_rec_q[c][b] <= def_rec(c, b);
			end
		end else if (fs_rise) begin
			act_hi_q  <= sh_hi_q;
			act_lo_q  <= sh_lo_q;
			act_rec_q <= sh_rec_q;
		end
	end

	// idle code while the algorithm is held in reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < CH; c++)
				reset_code_o[c*8 +: 8] <= CODE_FF;
		end else if (fs_rise) begin
			for (int c = 0; c < CH; c++)
				reset_code_o[c*8 +: 8] <=
					(sh_rec_q[c][RB_ALG][ALG_DEC_BIT] &&
					sh_lo_q[c][LO_ALAW]) ? CODE_ALAW : CODE_FF;
		end
	end

	// plain wiring from the active flops
	always_comb begin
		for (int c = 0; c < CH; c++) begin
			chan_decode_o[c] = act_rec_q[c][RB_ALG][ALG_DEC_BIT];
			route_in_y_o[c]  = act_rec_q[c][RB_ROUTE][RT_IN_BIT];
			route_out_y_o[c] = act_rec_q[c][RB_ROUTE][RT_OUT_BIT];
			alg_code_o[c*8 +: 8]       = act_rec_q[c][RB_ALG];
			in_slot_begin_o[c*8 +: 8]  = act_rec_q[c][RB_IN_B];
			in_slot_end_o[c*8 +: 8]    = act_rec_q[c][RB_IN_E];
			out_slot_begin_o[c*8 +: 8] = act_rec_q[c][RB_OUT_B];
			out_slot_end_o[c*8 +: 8]   = act_rec_q[c][RB_OUT_E];
			algo_reset_o[c]    = act_lo_q[c][LO_RESET];
			bypass_o[c]        = act_lo_q[c][LO_BYPASS];
			alaw_select_o[c]   = act_lo_q[c][LO_ALAW];
			idle_tristate_o[c] = act_lo_q[c][LO_IDLE];
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic       req;
	logic [2:0] vsel_q;
	logic [2:0] vs;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign vs  = vsel_q;

	// one wait state, ack dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_q <= CTRL_RST_VAL[0];
			vsel_q   <= '0;
		end else if (req && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == REG_CTRL)
				enable_q <= wb_dat_i[0];
			if (wb_adr_i == REG_SEL)
				vsel_q <= wb_dat_i[2:0];
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req && !wb_we_i) begin
			unique case (wb_adr_i)
				REG_CTRL:   wb_dat_o <= {31'h0, enable_q};
				REG_STATUS: wb_dat_o <= {8'h0, ign_cnt_q, cmd_cnt_q,
					3'h0, sel_act, 1'b0, 3'(state_q)} |
					{31'h0, config_pending_o} << 3;
				REG_SEL:    wb_dat_o <= {29'h0, vsel_q};
				REG_CTL:    wb_dat_o <= {16'h0, act_hi_q[vs], act_lo_q[vs]};
				REG_REC0:   wb_dat_o <= {act_rec_q[vs][RB_IN_B],
					act_rec_q[vs][RB_RSV], act_rec_q[vs][RB_ALG],
					act_rec_q[vs][RB_ROUTE]};
				REG_REC1:   wb_dat_o <= {8'h0, act_rec_q[vs][RB_OUT_E],
					act_rec_q[vs][RB_OUT_B], act_rec_q[vs][RB_IN_E]};
				default:    wb_dat_o <= '0;
			endcase
		end
	end

endmodule // acc_cmd_port

`default_nettype wire

// File: tb/acc_cmd_port_props.sv
// Purpose: concurrent checks on the command port outputs
// Assumes: one clock domain, synchronous active-high reset
// Notes:   frame sync age bounds when new settings may appear
`timescale 1ns/1ns
`default_nettype none
module acc_cmd_port_props #(
	parameter int CH = 8
) (
	input wire logic            clk_i,
	input wire logic            rst_i,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic            wb_ack_o,
	input wire logic            frame_sync_i,
	input wire logic            command_select_n_i,
	input wire logic [CH-1:0]   chan_decode_o,
	input wire logic [CH*8-1:0] alg_code_o,
	input wire logic [CH-1:0]   algo_reset_o,
	input wire logic [CH-1:0]   alaw_select_o,
	input wire logic [CH*8-1:0] reset_code_o,
	input wire logic            config_pending_o
);
	// ------------------------------------------------
	// helper logic
	// ------------------------------------------------
	logic [3:0]       fs_age_q;
	logic [4:0]       sel_age_q;
	logic [CH-1:0]    alg_dir;
	logic [CH*8-1:0]  exp_code;
	logic [CH*10-1:0] cfg;
	assign cfg = {alg_code_o, algo_reset_o, alaw_select_o};
	always_comb begin
		for (int c = 0; c < CH; c++) begin
			alg_dir[c] = alg_code_o[c*8+6];
			exp_code[c*8+:8] = (chan_decode_o[c] && alaw_select_o[c]) ?
				8'hd5 : 8'hff;
		end
	end
	// saturating ages, so a long quiet spell reads as the top value
	always_ff @(posedge clk_i)
		fs_age_q <= rst_i ? 4'hf : frame_sync_i ? 4'h0 :
			fs_age_q + {3'h0, fs_age_q != 4'hf};
	always_ff @(posedge clk_i)
		sel_age_q <= rst_i ? 5'h1f : !command_select_n_i ? 5'h00 :
			sel_age_q + {4'h0, sel_age_q != 5'h1f};
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_once;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_in_one:
		assert property (s_req |=> s_ack_once)
		else $error("ack not one pulse a cycle after request");
	a_ack_has_cause:
		assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	a_reset_defaults:
		assert property ($fell(rst_i) |-> algo_reset_o == '1 &&
			reset_code_o == '1 && !config_pending_o)
		else $error("defaults missing after reset");
	a_decode_default:
		assert property ($fell(rst_i) |-> chan_decode_o ==
			{{(CH-CH/2){1'b0}}, {(CH/2){1'b1}}})
		else $error("decode arrangement wrong after reset");
	a_decode_from_alg:
		assert property (chan_decode_o == alg_dir)
		else $error("decode direction differs from algorithm code");
	a_reset_code_value:
		assert property ($stable(alaw_select_o) && $stable(chan_decode_o) |->
			reset_code_o == exp_code)
		else $error("reset output code wrong");
	a_apply_at_frame:
		assert property ($changed(cfg) |-> fs_age_q <= 4'd8)
		else $error("settings changed away from a frame sync");
	a_pending_holds:
		assert property (config_pending_o && fs_age_q == 4'hf |=> config_pending_o)
		else $error("pending dropped without frame sync");
	a_pending_cause:
		assert property ($rose(config_pending_o) |-> sel_age_q < 5'd16)
		else $error("pending rose outside a select frame");
endmodule // acc_cmd_port_props
bind acc_cmd_port acc_cmd_port_props #(.CH(CH)) acc_cmd_port_props_inst (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .frame_sync_i,
	.command_select_n_i, .chan_decode_o, .alg_code_o, .algo_reset_o,
	.alaw_select_o, .reset_code_o, .config_pending_o
);
`default_nettype wire

// File: tb/acc_host_model.sv
// Purpose: host side of the three-wire command port
// Assumes: 160 ns link clock, held low outside frames
// Notes:   data moves while the link clock is low
`timescale 1ns/1ns
`default_nettype none
module acc_host_model (
	output logic sclk_o,
	output logic sdat_o,
	output logic sel_n_o
);
	initial begin
		sclk_o = 1'b0;
		sdat_o = 1'b0;
		sel_n_o = 1'b1;
	end
	// ------------------------------------------------
	// one select frame, bytes msb first
	// ------------------------------------------------
	task automatic frame(input logic [7:0] q[$]);
		#13 sel_n_o = 1'b0;
		foreach (q[i]) begin
			for (int k = 7; k >= 0; k--) begin
				#40 sdat_o = q[i][k];
				#40 sclk_o = 1'b1;
				#80 sclk_o = 1'b0;
			end
		end
		#80 sel_n_o = 1'b1;
		// released line must not keep the last bit
		sdat_o = ~sdat_o;
		#320;
	endtask
endmodule // acc_host_model
`default_nettype wire

// File: tb/tb_acc_cmd_port.sv
// Purpose: self-checking bench for the command port
// Assumes: chip id strapped to two
// Notes:   active settings are read on the ports and the views
`timescale 1ns/1ns
`default_nettype none
module tb_acc_cmd_port;
	import acc_pkg::*;
	logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic        fs, idh, idl, pend;
	logic [3:0]  wb_sel_i;
	logic [7:0]  wb_adr_i, dec, rin, rout, ars, byp, alw, idle;
	logic [7:0]  e_dec, e_rin, e_rout, e_ars, e_byp, e_alw, e_idle;
	logic [31:0] wb_dat_i, wb_dat_o, r;
	logic [63:0] alg, ib, ie, ob, oe, code;
	logic [63:0] e_alg, e_ib, e_ie, e_ob, e_oe, e_code;
	logic [7:0]  q[$];
	int          miscompares, comparisons;
	wire         sclk, sdat, seln;
	acc_host_model acc_host_model_inst (.sclk_o(sclk), .sdat_o(sdat),
		.sel_n_o(seln));
	acc_cmd_port acc_cmd_port_inst (
		.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
		.command_clock_i(sclk), .command_serial_in_i(sdat),
		.command_select_n_i(seln), .chip_id_high_i(idh),
		.chip_id_low_i(idl), .frame_sync_i(fs), .chan_decode_o(dec),
		.route_in_y_o(rin), .route_out_y_o(rout), .alg_code_o(alg),
		.in_slot_begin_o(ib), .in_slot_end_o(ie), .out_slot_begin_o(ob),
		.out_slot_end_o(oe), .algo_reset_o(ars), .bypass_o(byp),
		.alaw_select_o(alw), .idle_tristate_o(idle), .reset_code_o(code),
		.config_pending_o(pend)
	);
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] v);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i <= we;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		// only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		v = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		logic [31:0] v;
		wb(1'b0, a, 32'h0, v);
		chk(nm, {32'h0, e}, {32'h0, v});
	endtask
	task automatic send();
		acc_host_model_inst.frame(q);
		@(posedge clk_i);
	endtask
	task automatic apply();
		fs <= 1'b1;
		repeat (3) @(posedge clk_i);
		fs <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic defaults();
		for (int c = 0; c < 8; c++) begin
			e_alg[c*8+:8] = c < 4 ? 8'h5e : 8'h1e;
			e_ib[c*8+:8] = 8'(c % 4 * 16);
			e_ie[c*8+:8] = e_ib[c*8+:8] + (c < 4 ? 8'h03 : 8'h07);
			e_oe[c*8+:8] = e_ib[c*8+:8] + (c < 4 ? 8'h07 : 8'h03);
		end
		e_ob = e_ib;
		e_code = '1;
		{e_dec, e_rin, e_rout, e_ars} = {8'h0f, 8'h0f, 8'h0f, 8'hff};
		{e_byp, e_alw, e_idle} = '0;
	endtask
	task automatic chk_cfg();
		chk("flags", {e_dec, e_rin, e_rout, e_ars, e_byp, e_alw, e_idle,
			8'h0}, {dec, rin, rout, ars, byp, alw, idle, 8'h0});
		chk("algorithm", e_alg, alg);
		chk("in begin", e_ib, ib);
		chk("in end", e_ie, ie);
		chk("out begin", e_ob, ob);
		chk("out end", e_oe, oe);
		chk("reset code", e_code, code);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#500000;
		miscompares++;
		give_verdict();
	end
	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		rst_i = 1'b1;
		{wb_we_i, wb_cyc_i, wb_stb_i, fs} = '0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		{idh, idl} = 2'b10;
		miscompares = 0;
		comparisons = 0;
		defaults();
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk_cfg();
		rd(REG_CTRL, 32'h1, "enable");
		wb(1'b1, 8'h40, 32'hffff_ffff, r);
		rd(8'h40, 32'h0, "unmapped");
		// header for chip zero while strapped to two
		q = '{8'h30, 8'h02, 8'h00, 8'h00};
		send();
		chk("pending", 64'h0, {63'h0, pend});
		q = '{8'h32, 8'h02, 8'h00, 8'h14, 8'h00, 8'h08, 8'h00, 8'h05};
		send();
		chk("pending", 64'h1, {63'h0, pend});
		chk_cfg(); // held back until frame sync
		apply();
		{e_ars, e_byp, e_alw, e_idle} = {8'he7, 8'h08, 8'h14, 8'h10};
		e_code[23:16] = 8'hd5;
		chk_cfg();
		// trailing byte after the end marker must be dropped
		q = '{8'h00, 8'h40, 8'h1e, 8'ha5, 8'h20, 8'h27, 8'h30, 8'h33,
			8'hd0, 8'h5e, 8'h00, 8'h10, 8'h13, 8'h10, 8'h17, 8'hff, 8'h10};
		send();
		apply();
		{e_dec[0], e_rin[0], e_rout[0]} = 3'b001;
		e_alg[7:0] = 8'h1e;
		{e_ib[7:0], e_ie[7:0], e_ob[7:0], e_oe[7:0]} = 32'h2027_3033;
		chk_cfg();
		wb(1'b1, REG_SEL, 32'h0, r);
		rd(REG_REC0, 32'h20a5_1e40, "record word0");
		rd(REG_REC1, 32'h0033_3027, "record word1");
		wb(1'b1, REG_SEL, 32'h2, r);
		rd(REG_CTL, 32'h0000_0014, "control view");
		wb(1'b1, REG_CTRL, 32'h0, r);
		rd(REG_CTRL, 32'h0, "enable");
		q = '{8'h32, 8'h02, 8'h00, 8'h00};
		send();
		chk("pending", 64'h0, {63'h0, pend});
		// two headers taken, two refused, back in idle
		rd(REG_STATUS, 32'h0002_0200, "status");
		wb(1'b1, REG_CTRL, 32'h1, r);
		do_reset();
		defaults();
		chk_cfg();
		give_verdict();
	end
endmodule // tb_acc_cmd_port
`default_nettype wire
